// ### rtl/adc_ctrl_params.svh
// constants for the converter result and control block
// assumes a byte-addressed apb slave, one register per aligned word
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// register byte offsets
`define OFS_RESULT_LOW 8'h00
`define OFS_RESULT_MID 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_CLOCK_RATE 8'h0C
`define OFS_OPER_CTRL 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

// reset values
`define RST_RESULT 8'h00
`define RST_CLOCK_RATE 7'h00
`define RST_OPER_CTRL 8'h04
`define RST_IRQ 2'h0

// clock/rate control fields
`define CR_FACTOR_A_BIT 6
`define CR_DIV_BIT 5
`define CR_OSR_MSB 3

// operation control/status fields
`define OC_VREF_BIT 7
`define OC_LATCH_BIT 5
`define OC_EOC_BIT 4
`define OC_RST_BIT 3
`define OC_OFF_BIT 2
`define OC_SLP_BIT 1
`define OC_EDGE_BIT 0

// interrupt status fields
`define IRQ_DONE_BIT 0
`define IRQ_DROP_BIT 1

// modulator dividers and oversampling
`define DIV_SLOW 30
`define DIV_FAST 12
`define OSR_BASE 16'h8000
`define OSR_MAX_CODE 4'h8

`endif

// ### rtl/adc_ctrl_pkg.sv
// types shared by the converter result and control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package adc_ctrl_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [23:0] result_t;
  typedef enum logic {factor_a_doubled, factor_a_single} factor_a_e;
endpackage

`default_nettype wire

// ### rtl/result_byte_reg.sv
// one read-only result byte, loaded by hardware only
// assumes load is a single-cycle strobe in the pclk domain
`default_nettype none
`include "adc_ctrl_params.svh"

module result_byte_reg #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= WIDTH'(`RST_RESULT);
    end else if (load) begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// ### rtl/adc_result_control.sv
// apb register block for a 24-bit delta-sigma converter
// assumes sample_valid pulses once per finished conversion in pclk domain
//
// Functional notes
// R1: result is kept in three 8-bit registers, low, middle, high
// R2: bits 7..0 low, 15..8 middle, 23..16 high, order kept
// R3: results readable directly; writes to them change nothing
// R4: clock/rate control bit 7 always reads zero, writes ignored
// R5: clock/factor_a code picks factor and divide by 30 or 12
// R6: factor 2 doubles sampled data; factor 1 is low latency
// R7: oversampling ratio is 32768 shifted right by code, up to 8
// R8: 8-bit control registers set clock, rate, power, show end flag
// R9: operation control bit 6 always reads zero, writes ignored
// R10: software avoids reserved clock/factor_a and oversampling codes
// R11: all three result bytes load together from one conversion
`default_nettype none
`include "adc_ctrl_params.svh"

module adc_result_control
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] sample_data,
  input wire logic sample_valid,
  output logic irq,
  output logic modulator_clock,
  output logic [1:0] factor_a,
  output logic [15:0] oversampling_ratio,
  output logic converter_hold,
  output logic positive_reference_select,
  output logic edge_select
);

  localparam logic [4:0] HALF_SLOW = 5'(`DIV_SLOW / 2);
  localparam logic [4:0] HALF_FAST = 5'(`DIV_FAST / 2);
  localparam logic [7:0] OPER_RST = `RST_OPER_CTRL;

  // register state
  logic [6:0] clock_rate;
  logic vref_sel;
  logic latch_en;
  logic eoc;
  logic rst_bit;
  logic power_off;
  logic sleep_bit;
  logic edge_bit;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic latched;

  // result bytes
  reg_byte_t result_low;
  reg_byte_t result_mid;
  reg_byte_t result_high;

  // modulator divider
  logic [4:0] mod_count;
  logic [4:0] half;

  // bus decode
  logic access;
  logic wr_done;
  logic rd_start;
  logic addr_ok;
  reg_byte_t rd_byte;
  reg_byte_t oper_read;

  // events
  logic hold;
  logic capture;
  logic dropped;

  assign access = psel && penable;
  assign wr_done = access && pready && pwrite;
  assign rd_start = access && !pready;

  assign hold = rst_bit || power_off || sleep_bit;
  assign capture = sample_valid && !hold && !latched;
  assign dropped = sample_valid && !hold && latched;

  // R9
  assign oper_read = {vref_sel, 1'b0, latch_en, eoc, rst_bit, power_off, sleep_bit, edge_bit};

  // read decode
  always_comb begin
    rd_byte = 8'h00;
    addr_ok = 1'b1;
    if (paddr == `OFS_RESULT_LOW) begin
      rd_byte = result_low; // R2
    end else if (paddr == `OFS_RESULT_MID) begin
      rd_byte = result_mid; // R2
    end else if (paddr == `OFS_RESULT_HIGH) begin
      rd_byte = result_high; // R2
    end else if (paddr == `OFS_CLOCK_RATE) begin
      rd_byte = {1'b0, clock_rate}; // R4
    end else if (paddr == `OFS_OPER_CTRL) begin
      rd_byte = oper_read;
    end else if (paddr == `OFS_IRQ_STATUS) begin
      rd_byte = {6'h00, irq_status};
    end else if (paddr == `OFS_IRQ_MASK) begin
      rd_byte = {6'h00, irq_mask};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= rd_start;
      pslverr <= rd_start && !addr_ok;
      if (rd_start && !pwrite) begin
        prdata <= {24'h000000, rd_byte}; // R3
      end
    end
  end

  // clock and rate control, bit 7 not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_rate <= `RST_CLOCK_RATE;
    end else if (wr_done && paddr == `OFS_CLOCK_RATE) begin
      clock_rate <= pwdata[6:0]; // R4 R8
    end
  end

  // operation control, bit 6 not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_sel <= OPER_RST[`OC_VREF_BIT];
      latch_en <= OPER_RST[`OC_LATCH_BIT];
      rst_bit <= OPER_RST[`OC_RST_BIT];
      power_off <= OPER_RST[`OC_OFF_BIT];
      sleep_bit <= OPER_RST[`OC_SLP_BIT];
      edge_bit <= OPER_RST[`OC_EDGE_BIT];
    end else if (wr_done && paddr == `OFS_OPER_CTRL) begin
      vref_sel <= pwdata[`OC_VREF_BIT]; // R8 R9
      latch_en <= pwdata[`OC_LATCH_BIT];
      rst_bit <= pwdata[`OC_RST_BIT];
      power_off <= pwdata[`OC_OFF_BIT];
      sleep_bit <= pwdata[`OC_SLP_BIT];
      edge_bit <= pwdata[`OC_EDGE_BIT];
    end
  end

  // end of conversion flag, set wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc <= OPER_RST[`OC_EOC_BIT];
    end else if (capture) begin
      eoc <= 1'b1; // R8
    end else if (wr_done && paddr == `OFS_OPER_CTRL) begin
      eoc <= pwdata[`OC_EOC_BIT];
    end
  end

  // latch: first result after enable is held until enable clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b0;
    end else if (!latch_en) begin
      latched <= 1'b0;
    end else if (capture) begin
      latched <= 1'b1;
    end
  end

  // result bytes, loaded together from one sample
  result_byte_reg #(.WIDTH(8)) u_low (
    .pclk(pclk),
    .presetn(presetn),
    .load(capture), // R1 R11
    .d(sample_data[7:0]), // R2
    .q(result_low)
  );

  result_byte_reg #(.WIDTH(8)) u_mid (
    .pclk(pclk),
    .presetn(presetn),
    .load(capture), // R11
    .d(sample_data[15:8]), // R2
    .q(result_mid)
  );

  result_byte_reg #(.WIDTH(8)) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .load(capture), // R11
    .d(sample_data[23:16]), // R2
    .q(result_high)
  );

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `RST_IRQ;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `IRQ_DONE_BIT && capture) || (i == `IRQ_DROP_BIT && dropped)) begin
          irq_status[i] <= 1'b1;
        end else if (wr_done && paddr == `OFS_IRQ_STATUS && pwdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_done && paddr == `OFS_IRQ_MASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // modulator clock divider, reserved low code bit ignored
  assign half = clock_rate[`CR_DIV_BIT] ? HALF_FAST : HALF_SLOW; // R5 R10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_count <= 5'h00;
      modulator_clock <= 1'b0;
    end else if (hold) begin
      mod_count <= 5'h00;
      modulator_clock <= 1'b0;
    end else if (mod_count >= half - 5'h01) begin
      mod_count <= 5'h00;
      modulator_clock <= !modulator_clock; // R5
    end else begin
      mod_count <= mod_count + 5'h01;
    end
  end

  // decoded converter settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factor_a <= 2'h2;
      oversampling_ratio <= `OSR_BASE;
      converter_hold <= 1'b1;
      positive_reference_select <= 1'b0;
      edge_select <= 1'b0;
    end else begin
      if (factor_a_e'(clock_rate[`CR_FACTOR_A_BIT]) == factor_a_single) begin
        factor_a <= 2'h1; // R6
      end else begin
        factor_a <= 2'h2; // R6
      end
      if (clock_rate[`CR_OSR_MSB:0] >= `OSR_MAX_CODE) begin
        oversampling_ratio <= `OSR_BASE >> `OSR_MAX_CODE; // R7 R10
      end else begin
        oversampling_ratio <= `OSR_BASE >> clock_rate[2:0]; // R7
      end
      converter_hold <= hold;
      positive_reference_select <= vref_sel;
      edge_select <= edge_bit;
    end
  end

  // checks
  chk_result_read_only: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (wr_done && paddr == `OFS_RESULT_LOW && !capture) |=> $stable(result_low))
    else $error("result byte changed by a bus write");

  chk_clock_rate_top: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (pready && !pwrite && paddr == `OFS_CLOCK_RATE) |-> prdata[7] == 1'b0)
    else $error("clock/rate bit 7 read as one");

  chk_oper_bit_six: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (pready && !pwrite && paddr == `OFS_OPER_CTRL) |-> prdata[6] == 1'b0)
    else $error("operation control bit 6 read as one");

  chk_result_bytes_load: assert property (@(posedge pclk) disable iff (!presetn) // R2
    capture |=> {result_high, result_mid, result_low} == $past(sample_data))
    else $error("result bytes do not match the captured sample");

  chk_latched_hold: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (latched && latch_en) |=> $stable({result_high, result_mid, result_low}))
    else $error("latched result was overwritten");

  chk_fast_divider: assert property (@(posedge pclk) disable iff (!presetn) // R5
    ($rose(modulator_clock) && clock_rate[`CR_DIV_BIT]) |->
      ##12 ($rose(modulator_clock) || !clock_rate[`CR_DIV_BIT] || converter_hold))
    else $error("fast modulator clock period not 12");

  chk_factor_a_factor: assert property (@(posedge pclk) disable iff (!presetn) // R6
    1'b1 |=> factor_a == ($past(clock_rate[`CR_FACTOR_A_BIT]) ? 2'h1 : 2'h2))
    else $error("factor does not follow factor_a select");

  chk_osr_value: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (clock_rate[3:0] == 4'h8) |=> oversampling_ratio == 16'h0080)
    else $error("oversampling code 8 does not give 128");

  chk_eoc_on_done: assert property (@(posedge pclk) disable iff (!presetn) // R8
    capture |=> eoc && irq_status[`IRQ_DONE_BIT] ##1 (irq == irq_mask[`IRQ_DONE_BIT] || irq))
    else $error("end of conversion not flagged");

  chk_result_mid_ro: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (wr_done && paddr == `OFS_RESULT_MID && !capture) |=> $stable(result_mid))
    else $error("middle result byte changed by a bus write");

  chk_result_high_ro: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (wr_done && paddr == `OFS_RESULT_HIGH && !capture) |=> $stable(result_high))
    else $error("high result byte changed by a bus write");

  chk_drop_status: assert property (@(posedge pclk) disable iff (!presetn) // R11
    dropped |=> irq_status[`IRQ_DROP_BIT] && $stable({result_high, result_mid, result_low}))
    else $error("dropped sample not flagged or result changed");

  chk_irq_after_done: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (capture && irq_mask[`IRQ_DONE_BIT] && !wr_done) |-> ##2 irq)
    else $error("unmasked end of conversion gave no interrupt");

  chk_irq_masked_off: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (irq_mask == 2'h0 && !wr_done) |-> ##2 !irq)
    else $error("interrupt raised with all sources masked");

  chk_hold_clock_low: assert property (@(posedge pclk) disable iff (!presetn) // R8
    converter_hold |-> !modulator_clock)
    else $error("modulator clock runs while converter held");

  chk_osr_base: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (clock_rate[3:0] == 4'h0) |=> oversampling_ratio == 16'h8000)
    else $error("oversampling code 0 does not give 32768");

  chk_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn) // R8
    pslverr |-> pready)
    else $error("slave error without ready");

  chk_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // R8
    pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

endmodule

`default_nettype wire

// ### bench/tb_adc_result_control.sv
// self-checking bench for the converter result and control block
// assumes the apb slave answers with pready and samples pulse one cycle
`default_nettype none
`include "adc_ctrl_params.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h expected %h", $time, a, b); end end

module tb_adc_result_control;
  import adc_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] sample_data = 24'h0;
  logic sample_valid = 0;
  logic irq;
  logic modulator_clock;
  logic [1:0] factor_a;
  logic [15:0] oversampling_ratio;
  logic converter_hold;
  logic positive_reference_select;
  logic edge_select;
  logic [31:0] rdata;
  logic rerr;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  adc_result_control i_adc_result_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
    .sample_valid(sample_valid), .irq(irq), .modulator_clock(modulator_clock),
    .factor_a(factor_a), .oversampling_ratio(oversampling_ratio),
    .converter_hold(converter_hold),
    .positive_reference_select(positive_reference_select),
    .edge_select(edge_select)
  );

  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic sample(input logic [23:0] d);
    @(posedge pclk);
    sample_data <= d;
    sample_valid <= 1;
    @(posedge pclk);
    sample_valid <= 0;
    repeat (3) @(posedge pclk);
  endtask

  // pclk cycles between two rising edges of the modulator clock
  task automatic period_chk(input int exp_div);
    int n;
    int k;
    logic p;
    n = 0;
    k = 0;
    p = modulator_clock;
    for (int i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (k == 1) n++;
      if (modulator_clock === 1'b1 && p === 1'b0) k++;
      p = modulator_clock;
      if (k == 2) break;
    end
    `CHK(n, exp_div)
  endtask

  int codes[4] = '{0, 2, 4, 6};
  logic [1:0] facs[4] = '{2'd2, 2'd2, 2'd1, 2'd1};
  int divs[4] = '{30, 12, 30, 12};

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    xfer(0, `OFS_CLOCK_RATE, 0);
    `CHK(rdata, 32'h00000000)
    xfer(0, `OFS_OPER_CTRL, 0);
    `CHK(rdata, 32'h00000004)
    `CHK(converter_hold, 1'b1)
    xfer(1, `OFS_CLOCK_RATE, 32'h000000E8);
    xfer(0, `OFS_CLOCK_RATE, 0);
    `CHK(rdata, 32'h00000068)
    xfer(1, `OFS_OPER_CTRL, 32'h000000C1);
    xfer(0, `OFS_OPER_CTRL, 0);
    `CHK(rdata, 32'h00000081)
    `CHK({positive_reference_select, edge_select, converter_hold}, 3'b110)
    for (int i = 0; i < 4; i++) begin
      xfer(1, `OFS_CLOCK_RATE, 32'(codes[i] << 4));
      repeat (2) @(posedge pclk);
      `CHK(factor_a, facs[i])
      period_chk(divs[i]);
    end
    for (int c = 0; c <= 8; c++) begin
      xfer(1, `OFS_CLOCK_RATE, 32'(c));
      repeat (2) @(posedge pclk);
      `CHK(oversampling_ratio, 16'(32768 >> c))
    end
    xfer(1, `OFS_IRQ_MASK, 32'h00000001);
    sample(24'hABCDEF);
    xfer(0, `OFS_RESULT_LOW, 0);
    `CHK(rdata, 32'h000000EF)
    xfer(0, `OFS_RESULT_MID, 0);
    `CHK(rdata, 32'h000000CD)
    xfer(0, `OFS_RESULT_HIGH, 0);
    `CHK(rdata, 32'h000000AB)
    xfer(0, `OFS_OPER_CTRL, 0);
    `CHK(rdata[`OC_EOC_BIT], 1'b1)
    `CHK(irq, 1'b1)
    xfer(1, `OFS_IRQ_STATUS, 32'h00000001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    xfer(1, `OFS_RESULT_LOW, 32'h000000FF);
    xfer(0, `OFS_RESULT_LOW, 0);
    `CHK(rdata, 32'h000000EF)
    xfer(1, `OFS_OPER_CTRL, 32'h00000004);
    sample(24'h123456);
    xfer(0, `OFS_RESULT_HIGH, 0);
    `CHK(rdata, 32'h000000AB)
    xfer(1, `OFS_OPER_CTRL, 32'h00000000);
    xfer(1, `OFS_IRQ_MASK, 32'h00000000);
    sample(24'h123456);
    `CHK(irq, 1'b0)
    xfer(0, `OFS_RESULT_LOW, 0);
    `CHK(rdata, 32'h00000056)
    xfer(0, `OFS_RESULT_MID, 0);
    `CHK(rdata, 32'h00000034)
    xfer(0, `OFS_RESULT_HIGH, 0);
    `CHK(rdata, 32'h00000012)
    xfer(1, `OFS_OPER_CTRL, 32'h00000020);
    xfer(1, `OFS_IRQ_MASK, 32'h00000002);
    sample(24'h0A0B0C);
    sample(24'h0D0E0F);
    `CHK(irq, 1'b1)
    xfer(0, `OFS_RESULT_LOW, 0);
    `CHK(rdata, 32'h0000000C)
    xfer(0, `OFS_RESULT_HIGH, 0);
    `CHK(rdata, 32'h0000000A)
    xfer(0, `OFS_IRQ_STATUS, 0);
    `CHK(rdata, 32'h00000003)
    xfer(1, `OFS_IRQ_STATUS, 32'h00000003);
    xfer(1, `OFS_OPER_CTRL, 32'h00000002);
    xfer(0, `OFS_OPER_CTRL, 0);
    `CHK(rdata, 32'h00000002)
    `CHK({irq, converter_hold, modulator_clock}, 3'b010)
    xfer(1, `OFS_OPER_CTRL, 32'h00000008);
    sample(24'h111111);
    xfer(0, `OFS_RESULT_LOW, 0);
    `CHK(rdata, 32'h0000000C)
    xfer(0, `OFS_IRQ_STATUS, 0);
    `CHK(rdata, 32'h00000000)
    xfer(0, 8'h1C, 0);
    `CHK({rerr, rdata}, {1'b1, 32'h0})
    final_report();
  end
endmodule

`default_nettype wire
